// ### bench/mwc_asserts.sv
module mwc_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Master data driver
    input wire logic sda_oe_m,
    // Slave data driver
    input wire logic sda_oe_s,
    // Resolved bus wires
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;
    import mwc_pkg::*;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Wire history and bit slot counter
    // ------------------------------------------------------------
    logic scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
    logic [3:0] rise_reg, rise_next;
    logic start_seen, stop_seen;

    // Start and stop: data edge while the clock stays high
    assign start_seen = scl && scl_d_reg && sda_d_reg && !sda;
    assign stop_seen = scl && scl_d_reg && !sda_d_reg && sda;

    // Count clock rises in a nine-bit slot, restarted by a start
    always_comb begin
        scl_d_next = scl;
        sda_d_next = sda;
        rise_next = rise_reg;
        if (start_seen) begin
            rise_next = 4'h0;
        end else if (scl && !scl_d_reg) begin
            rise_next = (rise_reg == 4'h8) ? 4'h0 : rise_reg + 4'h1;
        end
    end

    // Register the history
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            rise_reg <= 4'h0;
        end else begin
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
            rise_reg <= rise_next;
        end
    end

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    start_owner_a: assert property (start_seen |-> sda_oe_m)
        else $error("start not made by master");
    stop_owner_a: assert property (stop_seen |->
        !sda_oe_s && !sda_oe_m && $past(sda_oe_m))
        else $error("stop not made by master");
    ack_enter_a: assert property ($rose(sda_oe_s) |-> !scl)
        else $error("slave grabbed data while clock high");
    ack_leave_a: assert property ($fell(sda_oe_s) |-> !scl)
        else $error("slave freed data while clock high");
    ack_hold_a: assert property ($rose(sda_oe_s) |-> sda_oe_s[*4])
        else $error("acknowledge too short");
    ack_slot_a: assert property (sda_oe_s |->
        rise_reg == 4'h8 || rise_reg == 4'h0)
        else $error("slave drove data outside ninth bit");
    idle_stop_a: assert property (stop_seen |=> !sda_oe_s[*8])
        else $error("slave active after stop");
    idle_clock_a: assert property (stop_seen |-> scl[*4])
        else $error("clock not idle after stop");
endmodule

// ### bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mwc_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock, rst_n, req_valid, req_ready, done, nack;
    logic [6:0] req_addr, dev;
    logic [1:0] req_count;
    logic [23:0] req_bytes;
    logic clock_select_strap, addr_strap, service_window_open;
    logic lin_lower, sw_lower, wd_en, win_en, wd_clr, nk;
    logic [3:0] lin_step, sw_step;
    logic [1:0] wd_per;
    logic [7:0] shift;
    logic [7:0] wire_q[$];
    int err_total, cmp_count, clr_count, nbit;

    mwc_bus_if mwc_bus_if_i ();
    mwc_master mwc_master_i (.clock(clock), .rst_n(rst_n),
        .bus(mwc_bus_if_i.master), .req_valid(req_valid),
        .req_addr(req_addr), .req_count(req_count),
        .req_bytes(req_bytes), .req_ready(req_ready), .done(done),
        .nack(nack));
    mwc_slave mwc_slave_i (.clock(clock), .rst_n(rst_n),
        .bus(mwc_bus_if_i.slave), .clock_select_strap(clock_select_strap),
        .addr_strap(addr_strap), .service_window_open(service_window_open),
        .linear_regulator_output_lower(lin_lower),
        .linear_regulator_output_step(lin_step),
        .switcher_output_lower(sw_lower), .switcher_output_step(sw_step),
        .watchdog_enabled(wd_en), .service_window_enabled(win_en),
        .watchdog_period(wd_per), .watchdog_clear(wd_clr));
    mwc_asserts mwc_asserts_i (.clock(clock), .rst_n(rst_n),
        .sda_oe_m(mwc_bus_if_i.sda_oe_m), .sda_oe_s(mwc_bus_if_i.sda_oe_s),
        .scl(mwc_bus_if_i.scl), .sda(mwc_bus_if_i.sda));

    // ------------------------------------------------------------
    // Clock, wire monitor, clear pulse counter
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // A start restarts bit collection
    always @(negedge mwc_bus_if_i.sda) begin
        if (mwc_bus_if_i.scl) nbit = 0;
    end

    // Shift data bits in, keep each byte at its acknowledge bit
    always @(posedge mwc_bus_if_i.scl) begin
        if (nbit < 8) shift = {shift[6:0], mwc_bus_if_i.sda};
        else wire_q.push_back(shift);
        nbit = (nbit == 8) ? 0 : nbit + 1;
    end

    // Sample the one-cycle clear pulse away from its launching edge
    always @(negedge clock) begin
        if (wd_clr === 1'b1) clr_count++;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_margin(input logic [4:0] el, input logic [4:0] es);
        chk("linear margin", {3'h0, el}, {3'h0, lin_lower, lin_step});
        chk("switcher margin", {3'h0, es}, {3'h0, sw_lower, sw_step});
    endtask

    task automatic chk_wd(input logic [3:0] e);
        chk("watchdog", {4'h0, e}, {4'h0, wd_en, win_en, wd_per});
    endtask

    task automatic do_reset(input logic [1:0] s);
        @(posedge clock);
        rst_n <= 1'b0;
        clock_select_strap <= s[1];
        addr_strap <= s[0];
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
    endtask

    // One transfer: request, then wait for done under a bound
    task automatic xfer(input logic [6:0] a, input logic [1:0] n,
                        input logic [23:0] b);
        int k;
        @(posedge clock);
        req_valid <= 1'b1;
        req_addr <= a;
        req_count <= n;
        req_bytes <= b;
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        chk("busy ready", 8'h00, {7'h0, req_ready});
        for (k = 0; k < 2000; k++) begin
            @(posedge clock);
            #1;
            if (done === 1'b1) break;
        end
        if (k == 2000) begin
            chk("done", 8'h01, 8'h00);
            close_out();
        end
        chk("idle ready", 8'h01, {7'h0, req_ready});
        nk = nack;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_straps();
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1:0]);
            xfer({ADDR_HIGH_BITS, i[1:0]}, 2'h0, 24'h0);
            chk("own address nack", 8'h00, {7'h0, nk});
            xfer({ADDR_HIGH_BITS, ~i[1:0]}, 2'h0, 24'h0);
            chk("other address nack", 8'h01, {7'h0, nk});
        end
        dev = {ADDR_HIGH_BITS, 2'h3};
        chk_margin(5'h00, 5'h00);
        chk_wd(4'h8);
        $display("test straps done");
    endtask

    task automatic t_margin();
        logic [7:0] eb[4];
        eb = '{{dev, 1'b0}, 8'h20, 8'h25, 8'h32};
        wire_q.delete();
        xfer(dev, 2'h3, 24'h202532);
        chk("nack", 8'h00, {7'h0, nk});
        chk_margin(5'h05, 5'h02);
        for (int i = 0; i < 4; i++) begin
            chk("wire byte", eb[i], wire_q[i]);
        end
        $display("test margin done");
    endtask

    task automatic t_lower();
        xfer(dev, 2'h3, 24'h203F29);
        chk_margin(5'h11, 5'h17);
        $display("test lower done");
    endtask

    task automatic t_unguarded();
        xfer(dev, 2'h1, 24'h2D0000);
        chk_margin(5'h11, 5'h17);
        xfer(dev, 2'h2, 24'h206A00);
        chk_wd(4'h8);
        xfer(dev, 2'h3, 24'h602200);
        chk_margin(5'h11, 5'h17);
        xfer(dev ^ 7'h01, 2'h2, 24'h202500);
        chk("stranger nack", 8'h01, {7'h0, nk});
        chk_margin(5'h11, 5'h17);
        xfer(dev, 2'h2, 24'h202B00);
        chk_margin(5'h13, 5'h17);
        $display("test unguarded done");
    endtask

    task automatic t_wdog();
        int c0;
        for (int i = 0; i < 8; i++) begin
            @(posedge clock);
            service_window_open <= i[0];
            c0 = clr_count;
            xfer(dev, 2'h2, {8'h60, 5'h0D, i[2:0], 8'h00});
            chk_wd({1'b1, i[2:0]});
            chk("clear pulses", {7'h0, i[0]}, 8'(clr_count - c0));
        end
        xfer(dev, 2'h2, 24'h606000);
        chk("enable", 8'h00, {7'h0, wd_en});
        xfer(dev, 2'h2, 24'h606400);
        chk_wd(4'h7);
        xfer(dev, 2'h2, 24'h606B00);
        chk_wd(4'hB);
        $display("test watchdog done");
    endtask

    // ------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clock);
        err_total++;
        $display("wrong value run time expected finish seen timeout");
        close_out();
    end

    initial begin
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_addr = 7'h00;
        req_count = 2'h0;
        req_bytes = 24'h000000;
        clock_select_strap = 1'b0;
        addr_strap = 1'b0;
        service_window_open = 1'b0;
        t_straps();
        t_margin();
        t_lower();
        t_unguarded();
        t_wdog();
        close_out();
    end
endmodule

// ### verilog/mwc_bus_if.sv
interface mwc_bus_if;
    // Open-drain wires: low when any party enables its driver
    logic scl_o_m;
    logic scl_oe_m;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;
    logic scl;
    logic sda;

    assign scl = !(scl_oe_m && !scl_o_m);
    assign sda = !((sda_oe_m && !sda_o_m) || (sda_oe_s && !sda_o_s));

    modport master (
        output scl_o_m, scl_oe_m, sda_o_m, sda_oe_m,
        input scl, sda
    );
    modport slave (
        output sda_o_s, sda_oe_s,
        input scl, sda
    );
endinterface

// ### verilog/mwc_master.sv
module mwc_master (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Two-wire bus
    mwc_bus_if.master bus,
    // Transfer request: address, count, up to three command bytes
    input wire logic req_valid,
    input wire logic [6:0] req_addr,
    input wire logic [1:0] req_count,
    input wire logic [23:0] req_bytes,
    output logic req_ready,
    // Result
    output logic done,
    output logic nack
);
    import mwc_pkg::*;

    typedef enum {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} mwc_mstate_t;

    mwc_mstate_t st_reg, st_next;
    logic [$clog2(QUARTER_CYCLES+1)-1:0] div_reg, div_next;
    logic [1:0] ph_reg, ph_next;
    logic [31:0] sh_reg, sh_next;
    logic [2:0] left_reg, left_next;
    logic [2:0] bit_reg, bit_next;
    logic scl_reg, scl_next, sda_reg, sda_next;
    logic done_reg, done_next, nack_reg, nack_next, ackin_reg, ackin_next;
    logic tick, sda_s;

    mwc_sync u_sda (.clock(clock), .rst_n(rst_n), .async_in(bus.sda),
        .sync_out(sda_s));

    // Quarter-bit tick from the divider
    always_comb begin
        tick = (div_reg == '0);
        div_next = tick ? ($bits(div_reg))'(QUARTER_CYCLES - 1)
            : div_reg - 1'b1;
    end

    // Bit sequencer: address with write bit, guard and command bytes
    always_comb begin
        st_next = st_reg;
        ph_next = ph_reg;
        sh_next = sh_reg;
        left_next = left_reg;
        bit_next = bit_reg;
        scl_next = scl_reg;
        sda_next = sda_reg;
        done_next = 1'b0;
        nack_next = nack_reg;
        ackin_next = ackin_reg;
        case (st_reg)
            M_IDLE: begin
                if (req_valid) begin
                    sh_next = {req_addr, 1'b0, req_bytes};
                    left_next = {1'b0, req_count} + 3'h1;
                    bit_next = 3'h7;
                    nack_next = 1'b0;
                    ph_next = 2'h0;
                    st_next = M_START;
                end
            end
            M_START: if (tick) begin
                sda_next = 1'b0;
                if (ph_reg == 2'h1) begin
                    scl_next = 1'b0;
                    st_next = M_BIT;
                    ph_next = 2'h0;
                end else ph_next = ph_reg + 2'h1;
            end
            M_BIT, M_ACK: if (tick) begin
                ph_next = ph_reg + 2'h1;
                case (ph_reg)
                    2'h0: sda_next = (st_reg == M_BIT) ? sh_reg[31] : 1'b1;
                    2'h1: scl_next = 1'b1;
                    2'h2: ackin_next = sda_s;
                    default: begin
                        scl_next = 1'b0;
                        if (st_reg == M_BIT) begin
                            sh_next = {sh_reg[30:0], 1'b0};
                            bit_next = bit_reg - 3'h1;
                            if (bit_reg == 3'h0) st_next = M_ACK;
                        end else begin
                            left_next = left_reg - 3'h1;
                            bit_next = 3'h7;
                            nack_next = nack_reg | ackin_reg;
                            if (ackin_reg || left_reg == 3'h1) begin
                                st_next = M_STOP;
                            end else st_next = M_BIT;
                        end
                    end
                endcase
            end
            M_STOP: if (tick) begin
                // Master alone ends the transfer
                ph_next = ph_reg + 2'h1;
                case (ph_reg)
                    2'h0: sda_next = 1'b0;
                    2'h1: scl_next = 1'b1;
                    2'h2: sda_next = 1'b1;
                    default: begin
                        done_next = 1'b1;
                        st_next = M_IDLE;
                    end
                endcase
            end
            default: st_next = M_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= M_IDLE;
            div_reg <= '0;
            ph_reg <= 2'h0;
            sh_reg <= 32'h0000_0000;
            left_reg <= 3'h0;
            bit_reg <= 3'h0;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            ackin_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            div_reg <= div_next;
            ph_reg <= ph_next;
            sh_reg <= sh_next;
            left_reg <= left_next;
            bit_reg <= bit_next;
            scl_reg <= scl_next;
            sda_reg <= sda_next;
            done_reg <= done_next;
            nack_reg <= nack_next;
            ackin_reg <= ackin_next;
        end
    end

    // Open-drain drive: enable only when pulling low
    assign bus.scl_o_m = 1'b0;
    assign bus.scl_oe_m = !scl_reg;
    assign bus.sda_o_m = 1'b0;
    assign bus.sda_oe_m = !sda_reg;
    assign req_ready = (st_reg == M_IDLE);
    assign done = done_reg;
    assign nack = nack_reg;
endmodule

// ### verilog/mwc_pkg.sv
package mwc_pkg;
    // ------------------------------------------------------------
    // Command byte layout
    // ------------------------------------------------------------
    localparam int ADDR_HI = 7;
    localparam int ADDR_LO = 5;
    localparam logic [2:0] OP_MARGIN = 3'h1;
    localparam logic [2:0] OP_WDOG = 3'h3;
    localparam logic [4:0] VALUE_NULL = 5'h00;
    localparam int MV_SUPPLY = 4;
    localparam int MV_SIGN = 3;
    localparam int WV_PERIOD_VALID = 3;
    localparam int WV_WINDOW = 2;

    // ------------------------------------------------------------
    // Slave address and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_HIGH_BITS = 5'h0A; // Arbitrary high-order bits
    localparam logic [3:0] STEP_NOMINAL = 4'h0;
    localparam logic [1:0] PERIOD_RESET = 2'h0;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ------------------------------------------------------------
    // Timing: bus clock divider in the master end
    // ------------------------------------------------------------
    localparam int CLK_NS = 100;
    localparam int BIT_NS = 800;
    localparam int QUARTER_CYCLES = (BIT_NS / 4 + CLK_NS - 1) / CLK_NS;
endpackage

// ### verilog/mwc_slave.sv
// Functional notes
// - Guard byte: operation code, zero value
// - Master sends guard before setting byte
// - Unguarded command bytes change nothing
// - Two margin bytes after one guard
// - Master services watchdog periodically
// - Guarded watchdog write clears timer in window
// - Watchdog guard sent twice disables watchdog
// - Later guarded period command restarts watchdog
// - Only master ends transfer with stop
// - Stop returns slave to idle
// - Master always addresses with write bit
// - Margin value 00101 raises linear by 5%
// - Byte 001 10010 sets switcher +2%
// - Address low bits from two straps
module mwc_slave (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Two-wire bus
    mwc_bus_if.slave bus,
    // Address straps
    input wire logic clock_select_strap,
    input wire logic addr_strap,
    // Watchdog status from timer
    input wire logic service_window_open,
    // Margining settings
    output logic linear_regulator_output_lower,
    output logic [3:0] linear_regulator_output_step,
    output logic switcher_output_lower,
    output logic [3:0] switcher_output_step,
    // Watchdog settings
    output logic watchdog_enabled,
    output logic service_window_enabled,
    output logic [1:0] watchdog_period,
    output logic watchdog_clear
);
    import mwc_pkg::*;

    typedef enum {ST_IDLE, ST_ADDR, ST_ACK, ST_DATA, ST_IGNORE} mwc_state_t;
    typedef enum {G_NONE, G_MARGIN, G_WDOG} mwc_guard_t;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic scl_s;
    logic sda_s;
    mwc_sync u_scl (.clock(clock), .rst_n(rst_n), .async_in(bus.scl),
        .sync_out(scl_s));
    mwc_sync u_sda (.clock(clock), .rst_n(rst_n), .async_in(bus.sda),
        .sync_out(sda_s));
    logic cs_s;
    logic ad_s;
    mwc_sync u_cs (.clock(clock), .rst_n(rst_n),
        .async_in(clock_select_strap), .sync_out(cs_s));
    mwc_sync u_ad (.clock(clock), .rst_n(rst_n),
        .async_in(addr_strap), .sync_out(ad_s));

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    mwc_state_t st_reg, st_next;
    mwc_guard_t gd_reg, gd_next;
    logic scl_d_reg, scl_d_next, sda_d_reg, sda_d_next;
    logic [7:0] sh_reg, sh_next;
    logic [3:0] cnt_reg, cnt_next;
    logic ack_reg, ack_next;
    logic is_addr_reg, is_addr_next;
    logic [6:0] my_addr_reg, my_addr_next;
    logic ll_reg, ll_next, sl_reg, sl_next;
    logic [3:0] lp_reg, lp_next, sp_reg, sp_next;
    logic wen_reg, wen_next, win_reg, win_next, clr_reg, clr_next;
    logic [1:0] per_reg, per_next;

    logic scl_rise, scl_fall, start_c, stop_c;
    logic [7:0] byte_in;

    // Edge and bus-condition detection on synchronised copies
    always_comb begin
        scl_rise = scl_s && !scl_d_reg;
        scl_fall = !scl_s && scl_d_reg;
        start_c = scl_s && scl_d_reg && sda_d_reg && !sda_s;
        stop_c = scl_s && scl_d_reg && !sda_d_reg && sda_s;
        byte_in = {sh_reg[6:0], sda_s};
    end

    // Next-state logic
    always_comb begin
        st_next = st_reg;
        gd_next = gd_reg;
        scl_d_next = scl_s;
        sda_d_next = sda_s;
        sh_next = sh_reg;
        cnt_next = cnt_reg;
        ack_next = ack_reg;
        is_addr_next = is_addr_reg;
        my_addr_next = my_addr_reg;
        ll_next = ll_reg;
        sl_next = sl_reg;
        lp_next = lp_reg;
        sp_next = sp_reg;
        wen_next = wen_reg;
        win_next = win_reg;
        per_next = per_reg;
        clr_next = 1'b0;
        // Straps followed while the bus idles, frozen during a transfer
        if (st_reg == ST_IDLE) begin
            my_addr_next = {ADDR_HIGH_BITS, cs_s, ad_s};
        end
        if (stop_c) begin
            st_next = ST_IDLE;
            gd_next = G_NONE;
            ack_next = 1'b0;
        end else if (start_c) begin
            st_next = ST_ADDR; // start or repeated start
            gd_next = G_NONE;
            cnt_next = 4'h0;
            is_addr_next = 1'b1;
            ack_next = 1'b0;
        end else begin
            case (st_reg)
                ST_ADDR, ST_DATA: begin
                    if (scl_rise) begin
                        sh_next = byte_in;
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (scl_fall && cnt_reg == 4'h8) begin
                        cnt_next = 4'h0;
                        st_next = ST_ACK;
                        ack_next = 1'b1;
                        if (is_addr_reg) begin
                            // Only a write to our address is taken
                            if (sh_reg != {my_addr_reg, 1'b0}) begin
                                st_next = ST_IGNORE;
                                ack_next = 1'b0;
                            end
                        end else if (sh_reg[4:0] == VALUE_NULL &&
                            sh_reg[ADDR_HI:ADDR_LO] == OP_WDOG &&
                            gd_reg == G_WDOG) begin
                            // Guard repeated: watchdog off
                            wen_next = 1'b0;
                            gd_next = G_NONE;
                        end else if (sh_reg[4:0] == VALUE_NULL) begin
                            // Guard byte arms its operation
                            gd_next = G_NONE;
                            if (sh_reg[ADDR_HI:ADDR_LO] == OP_MARGIN)
                                gd_next = G_MARGIN;
                            if (sh_reg[ADDR_HI:ADDR_LO] == OP_WDOG)
                                gd_next = G_WDOG;
                        end else if (sh_reg[ADDR_HI:ADDR_LO] == OP_MARGIN &&
                            gd_reg == G_MARGIN) begin
                            // Guard stays armed for second supply
                            if (sh_reg[MV_SUPPLY]) begin
                                sl_next = sh_reg[MV_SIGN];
                                sp_next = {1'b0, sh_reg[2:0]};
                            end else begin
                                ll_next = sh_reg[MV_SIGN];
                                lp_next = {1'b0, sh_reg[2:0]};
                            end
                        end else if (sh_reg[ADDR_HI:ADDR_LO] == OP_WDOG &&
                            gd_reg == G_WDOG &&
                            sh_reg[WV_PERIOD_VALID]) begin
                            win_next = sh_reg[WV_WINDOW];
                            per_next = sh_reg[1:0];
                            wen_next = 1'b1;
                            clr_next = service_window_open;
                            gd_next = G_NONE;
                        end else begin
                            gd_next = G_NONE;
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        ack_next = 1'b0;
                        is_addr_next = 1'b0;
                        st_next = ST_DATA;
                    end
                end
                ST_IGNORE, ST_IDLE: begin
                    st_next = st_reg;
                end
                default: st_next = ST_IDLE;
            endcase
        end
    end

    // Registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            gd_reg <= G_NONE;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            sh_reg <= BYTE_ZERO;
            cnt_reg <= 4'h0;
            ack_reg <= 1'b0;
            is_addr_reg <= 1'b0;
            my_addr_reg <= 7'h00;
            ll_reg <= 1'b0;
            sl_reg <= 1'b0;
            lp_reg <= STEP_NOMINAL;
            sp_reg <= STEP_NOMINAL;
            wen_reg <= 1'b1;
            win_reg <= 1'b0;
            per_reg <= PERIOD_RESET;
            clr_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            gd_reg <= gd_next;
            scl_d_reg <= scl_d_next;
            sda_d_reg <= sda_d_next;
            sh_reg <= sh_next;
            cnt_reg <= cnt_next;
            ack_reg <= ack_next;
            is_addr_reg <= is_addr_next;
            my_addr_reg <= my_addr_next;
            ll_reg <= ll_next;
            sl_reg <= sl_next;
            lp_reg <= lp_next;
            sp_reg <= sp_next;
            wen_reg <= wen_next;
            win_reg <= win_next;
            per_reg <= per_next;
            clr_reg <= clr_next;
        end
    end

    // Outputs; acknowledge pulls data low
    assign bus.sda_o_s = 1'b0;
    assign bus.sda_oe_s = ack_reg;
    assign linear_regulator_output_lower = ll_reg;
    assign linear_regulator_output_step = lp_reg;
    assign switcher_output_lower = sl_reg;
    assign switcher_output_step = sp_reg;
    assign watchdog_enabled = wen_reg;
    assign service_window_enabled = win_reg;
    assign watchdog_period = per_reg;
    assign watchdog_clear = clr_reg;
endmodule

// ### verilog/mwc_sync.sv
module mwc_sync (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Asynchronous level and its synchronised copy
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_reg;
    logic sync_next;

    // Two flops; the first feeds only the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule
